// ### tmr_checker.sv
// Checker for the register-bank link: strobes, answers, masked writes
// Assumes it sits beside the one link that joins host and device
`timescale 1ns/1ps
module tmr_checker
  import tmr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic ptr_only,
  input wire logic [7:0] wr_ptr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  logic [7:0] ptr_reg;
  logic [7:0] cfg_reg;
  logic [7:0] rate_reg;
  // Write ports count as known so a read of them is not judged
  wire known_w = ptr_reg inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h09, 8'h0a, 8'h10};
  // Shadow of pointer, config and rate rebuilt from link writes
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ptr_reg <= PTR_RESET;
      cfg_reg <= CFG_RESET;
      rate_reg <= RATE_RESET;
    end else if (wr_stb) begin
      ptr_reg <= wr_ptr;
      if (!ptr_only && wr_ptr == ADDR_CFG_WR) cfg_reg <= wr_data & CFG_WR_MASK;
      if (!ptr_only && wr_ptr == ADDR_RATE_WR) rate_reg <= wr_data & RATE_WR_MASK;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  AST_RD_ANSWER: assert property (rd_stb |=> rd_valid) else $error("read answer missing");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_stb)) else $error("answer without read");
  AST_STB_EXCL: assert property (!(wr_stb && rd_stb)) else $error("read and write together");
  AST_RD_HOLD: assert property (!rd_stb |=> $stable(rd_data)) else $error("read data moved");
  AST_CFG_RD: assert property (rd_stb && ptr_reg == ADDR_CFG_RD |=> rd_data == cfg_reg)
    else $error("config readback wrong");
  AST_RATE_RD: assert property (rd_stb && ptr_reg == ADDR_RATE_RD |=> rd_data == rate_reg)
    else $error("rate readback wrong");
  AST_FRAC_LOW: assert property (rd_stb && ptr_reg == ADDR_REM_FRAC |=> rd_data[5:0] == 6'h00)
    else $error("fraction low bits set");
  AST_UNMAPPED: assert property (rd_stb && !known_w |=> rd_data == UNMAPPED_READ)
    else $error("unmapped read not zero");
  AST_CFG_WMASK: assert property (wr_stb && !ptr_only && wr_ptr == ADDR_CFG_WR |->
    (wr_data & ~CFG_WR_MASK) == 8'h00) else $error("reserved config bits written");
  AST_RATE_WMASK: assert property (wr_stb && !ptr_only && wr_ptr == ADDR_RATE_WR |-> wr_data[7:4] == 4'h0)
    else $error("rate upper bits written");
endmodule

// ### tmr_device.sv
// Temperature monitor register bank: results, pointer, configuration, rate
// Assumes a converter model drives signed 10-bit samples; one clock, sync reset
// Assumes limit comparison sits outside and hands in the three alarm flags
// Function
// - Local result at address 0x00, whole degrees
// - Remote result split: integer 0x01, fraction 0x10
// - Fraction uses bits 7:6 only, rest zero
// - Host reads both remote bytes back to back
// - Config bit 2 selects extended range
// - New range valid from next conversion
// - Default range binary, clamped 0 to 127
// - Extended range adds 64 degree offset
// - Extended registers span -64 to +191
// - Shorted diode keeps last remote result
// - Range change leaves limits; host reprograms
// - First write byte loads pointer, second writes
// - Pointer resets to 0x00
// - Results converter-only, read-only, reset 0x00
// - Config read 0x03, write 0x09, reset 0x00
// - Bit 7 masks interrupt unless pin6 second overtemp
// - Bit 6 standby stops conversions, outputs live
// - Bit 5 picks pin 6 function
// - Rate read 0x04, write 0x0a
// - Rate divides oscillator by power of two
// - Rate resets 0x08; period covers both channels
// - Host writes zero to rate upper nibble
// - Codes 0x00-0x0a valid, above reserved
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tmr_device (
  input wire logic i_clock,
  input wire logic i_rst_b,
  tmr_if.device bus,
  input wire logic signed [9:0] i_local_temp,
  input wire logic signed [9:0] i_remote_temp,
  input wire logic [1:0] i_remote_quarter,
  input wire logic i_remote_short,
  input wire logic i_alarm_flag,
  input wire logic i_overtemp_flag,
  input wire logic i_high_flag,
  output logic o_irq_output_b,
  output logic o_overtemp_output_b,
  output logic o_conv_strobe,
  output logic o_standby
);
  import tmr_pkg::*;

  localparam int CNT_W = 28;

  logic [7:0] ptr_reg;
  logic [7:0] local_reg;
  logic [7:0] rem_int_reg;
  logic [7:0] rem_frac_reg;
  logic [7:0] cfg_reg;
  logic [7:0] rate_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic irq_b_reg;
  logic ot_b_reg;
  logic conv_reg;
  logic standby_reg;

  // Formatting: extended uses offset binary, default clamps
  // Extended clamps at the ends of the byte, default at 0 and 127
  function automatic logic [7:0] fmt(input logic signed [9:0] t, input logic ext);
    logic [9:0] off;
    off = 10'(t) + EXT_OFFSET;
    if (ext) begin
      if (t < -10'sd64) begin
        fmt = BIN_MIN;
      end else if (off > EXT_MAX) begin
        fmt = EXT_MAX[7:0];
      end else begin
        fmt = off[7:0];
      end
    end else if (t < 0) begin
      fmt = BIN_MIN;
    end else if (t > $signed({2'b00, BIN_MAX})) begin
      fmt = BIN_MAX;
    end else begin
      fmt = t[7:0];
    end
  endfunction

  // Period in clocks: the code clamps at the fastest legal value
  wire [3:0] rate_code = (rate_reg[3:0] > RATE_MAX_CODE) ? RATE_MAX_CODE : rate_reg[3:0];
  wire [3:0] rate_shift = RATE_MAX_CODE - rate_code;
  wire [CNT_W-1:0] period = CNT_W'(FAST_PERIOD_CYC) << rate_shift;
  wire running = ~cfg_reg[CFG_STANDBY_BIT];
  // A conversion runs at the start of each period, so leaving standby gives a fresh
  // result at once; the counter then waits out the rest of the period
  wire at_end = cnt_reg >= period - CNT_W'(1);
  wire conv_done = running && (cnt_reg == '0);
  wire ext_range = cfg_reg[CFG_RANGE_BIT];
  wire data_wr = bus.wr_stb && !bus.ptr_only;
  wire pin6_second = cfg_reg[CFG_PIN6_BIT];

  // Pin 6 level: second overtemp ignores the mask, alert mode honours it
  wire alert_level = i_alarm_flag && !cfg_reg[CFG_IRQ_MASK_BIT];
  wire pin6_low = pin6_second ? i_high_flag : alert_level;

  // One formatter per channel, 0 local and 1 remote; both share the range bit
  localparam int NUM_CHAN = 2;
  logic signed [9:0] chan_temp [NUM_CHAN];
  logic [7:0] chan_fmt [NUM_CHAN];
  assign chan_temp[0] = i_local_temp;
  assign chan_temp[1] = i_remote_temp;
  generate
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      assign chan_fmt[ch] = fmt(chan_temp[ch], ext_range);
    end
  endgenerate

  // Read mux on the pointer
  // The write-only addresses fall to the default and read as zero
  logic [7:0] rd_mux;
  always_comb begin
    case (ptr_reg)
      ADDR_LOCAL: rd_mux = local_reg;
      ADDR_REM_INT: rd_mux = rem_int_reg;
      ADDR_REM_FRAC: rd_mux = rem_frac_reg & FRAC_MASK;
      ADDR_CFG_RD: rd_mux = cfg_reg;
      ADDR_RATE_RD: rd_mux = rate_reg;
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  // Pointer and writable registers; result registers take no bus write
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ptr_reg <= PTR_RESET;
      cfg_reg <= CFG_RESET;
      rate_reg <= RATE_RESET;
    end else begin
      // A pointer-only write moves the pointer and nothing else
      if (bus.wr_stb) begin
        ptr_reg <= bus.wr_ptr;
      end
      if (data_wr && bus.wr_ptr == ADDR_CFG_WR) begin
        cfg_reg <= bus.wr_data & CFG_WR_MASK;
      end
      if (data_wr && bus.wr_ptr == ADDR_RATE_WR) begin
        rate_reg <= bus.wr_data & RATE_WR_MASK;
      end
    end
  end

  // Conversion timer; one period updates both channels at once
  // Standby holds the count at zero, so the first running edge converts
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
      conv_reg <= 1'b0;
    end else begin
      conv_reg <= conv_done;
      if (!running || at_end) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // Results: range sampled at store time, so new format applies next conversion
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      local_reg <= RESULT_RESET;
      rem_int_reg <= RESULT_RESET;
      rem_frac_reg <= RESULT_RESET;
    end else if (conv_done) begin
      local_reg <= chan_fmt[0];
      // Shorted diode: both remote bytes keep their last good pair
      if (!i_remote_short) begin
        rem_int_reg <= chan_fmt[1];
        rem_frac_reg <= {i_remote_quarter, 6'h00};
      end
    end
  end

  // Pins and readback; alarm pins stay live in standby
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rd_data_reg <= UNMAPPED_READ;
      rd_valid_reg <= 1'b0;
      irq_b_reg <= 1'b1;
      ot_b_reg <= 1'b1;
      standby_reg <= 1'b0;
    end else begin
      // Answer one cycle after the strobe; data stands until the next read
      rd_valid_reg <= bus.rd_stb;
      if (bus.rd_stb) begin
        rd_data_reg <= rd_mux;
      end
      irq_b_reg <= ~pin6_low;
      ot_b_reg <= ~i_overtemp_flag;
      standby_reg <= cfg_reg[CFG_STANDBY_BIT];
    end
  end

  // Every output comes straight from a flip-flop
  assign bus.rd_data = rd_data_reg;
  assign bus.rd_valid = rd_valid_reg;
  assign o_irq_output_b = irq_b_reg;
  assign o_overtemp_output_b = ot_b_reg;
  assign o_conv_strobe = conv_reg;
  assign o_standby = standby_reg;
endmodule

// ### tmr_host.sv
// Host controller: AHB-Lite slave registers driving the register-bank link
// Assumes single word transfers, OKAY only; one clock shared with the device
`timescale 1ns/1ps
module tmr_host (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  tmr_if.host link
);
  import tmr_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_DONE = 3'b100
  } tmr_hstate_t;

  tmr_hstate_t state_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic busy_reg;
  logic wr_stb_reg;
  logic rd_stb_reg;
  logic ptr_only_reg;
  logic ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] hrdata_reg;

  // Address phase capture; the slave is always ready
  wire ap_valid = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  wire dp_write = ap_wr_reg;
  wire go = dp_write && ap_addr_reg == HC_CMD && (i_hwdata & HC_CMD_GO_BIT) != 32'h0 && !busy_reg;
  wire [31:0] status_word = {31'h0, busy_reg};
  wire [31:0] rd_word = (i_haddr == HC_STATUS) ? status_word :
                        (i_haddr == HC_RDATA) ? {24'h0, rdata_reg} :
                        (i_haddr == HC_WDATA) ? {24'h0, wdata_reg} :
                        (i_haddr == HC_CMD) ? {24'h0, ptr_reg} : 32'h0;

  // Bus slave: hrdata registered at the address phase edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
      wdata_reg <= 8'h00;
    end else begin
      ap_wr_reg <= ap_valid && i_hwrite;
      ap_addr_reg <= i_haddr;
      if (ap_valid && !i_hwrite) begin
        hrdata_reg <= rd_word;
      end
      if (dp_write && ap_addr_reg == HC_WDATA) begin
        wdata_reg <= i_hwdata[7:0];
      end
    end
  end

  // Link sequencer: one strobe per command, wait for read answer
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_reg <= HS_IDLE;
      ptr_reg <= PTR_RESET;
      busy_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      ptr_only_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (go) begin
            busy_reg <= 1'b1;
            if (i_hwdata[HC_CMD_WR_BIT]) begin
              ptr_reg <= i_hwdata[7:0];
              wr_stb_reg <= 1'b1;
              ptr_only_reg <= i_hwdata[HC_CMD_PTR_ONLY_BIT];
              state_reg <= HS_DONE;
            end else begin
              rd_stb_reg <= 1'b1;
              state_reg <= HS_WAIT;
            end
          end
        end
        HS_WAIT: begin
          if (link.rd_valid) begin
            rdata_reg <= link.rd_data;
            state_reg <= HS_DONE;
          end
        end
        HS_DONE: begin
          busy_reg <= 1'b0;
          state_reg <= HS_IDLE;
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // Host masks the reserved bits so they are always written as zero
  wire [7:0] wr_masked = (ptr_reg == ADDR_RATE_WR) ? (wdata_reg & RATE_WR_MASK) :
                         (ptr_reg == ADDR_CFG_WR) ? (wdata_reg & CFG_WR_MASK) : wdata_reg;

  assign link.wr_stb = wr_stb_reg;
  assign link.rd_stb = rd_stb_reg;
  assign link.ptr_only = ptr_only_reg;
  assign link.wr_ptr = ptr_reg;
  assign link.wr_data = wr_masked;
  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule

// ### tmr_if.sv
// Link between the register bank and its host controller
// Assumes one clock; the host owns the request, the device owns the answer
`timescale 1ns/1ps
interface tmr_if;
  logic wr_stb;
  logic rd_stb;
  logic ptr_only;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic rd_valid;
  modport device (input wr_stb, rd_stb, ptr_only, wr_ptr, wr_data, output rd_data, rd_valid);
  modport host (output wr_stb, rd_stb, ptr_only, wr_ptr, wr_data, input rd_data, rd_valid);
endinterface

// ### tmr_pkg.sv
// Package for the temperature monitor register bank and its host controller
// Assumes both ends and the bench import it; one 10 MHz clock for everything
package tmr_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_LOCAL = 8'h00;
  localparam logic [7:0] ADDR_REM_INT = 8'h01;
  localparam logic [7:0] ADDR_CFG_RD = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD = 8'h04;
  localparam logic [7:0] ADDR_CFG_WR = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR = 8'h0a;
  localparam logic [7:0] ADDR_REM_FRAC = 8'h10;
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Configuration fields
  localparam int CFG_IRQ_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_PIN6_BIT = 5;
  localparam int CFG_RANGE_BIT = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'he4;
  // Rate field
  localparam logic [7:0] RATE_WR_MASK = 8'h0f;
  localparam logic [3:0] RATE_MAX_CODE = 4'ha;
  // Data formats
  localparam logic [7:0] BIN_MAX = 8'h7f;
  localparam logic [7:0] BIN_MIN = 8'h00;
  localparam logic [9:0] EXT_OFFSET = 10'h040;
  localparam logic [9:0] EXT_MAX = 10'h0ff;
  localparam logic [7:0] FRAC_MASK = 8'hc0;
  // Timing: fastest conversion period 15.5 ms = 15500 us; multiply by 2**(10-code)
  localparam int CLK_MHZ = 10;
  localparam int FAST_PERIOD_US = 15500;
  localparam int FAST_PERIOD_CYC = FAST_PERIOD_US * CLK_MHZ;
  // AHB-Lite controller register offsets
  localparam logic [7:0] HC_CMD = 8'h00;
  localparam logic [7:0] HC_WDATA = 8'h04;
  localparam logic [7:0] HC_STATUS = 8'h08;
  localparam logic [7:0] HC_RDATA = 8'h0c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] HC_CMD_GO_BIT = 32'h0000_0100;
  localparam int HC_CMD_WR_BIT = 9;
  localparam int HC_CMD_PTR_ONLY_BIT = 10;
endpackage

// ### tmr_tb_top.sv
// Bench joining host controller and register bank through the link
// Assumes AHB-Lite zero-wait slave; conversions only at reset release and standby exit
`timescale 1ns/1ps
module tmr_tb_top;
  import tmr_pkg::*;
  localparam logic [31:0] WR_CMD = 32'h1 << HC_CMD_WR_BIT;
  localparam logic [31:0] PTR_CMD = WR_CMD | (32'h1 << HC_CMD_PTR_ONLY_BIT);
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rv, lfsr_reg = 32'h7acb3ea0;
  logic signed [9:0] ltemp = 10'sh019, rtemp = 10'sh000;
  logic [1:0] rquart = 2'h0;
  logic rshort = 1'b0, alarm = 1'b0, otemp = 1'b0, high = 1'b0, irq_b, ot_b, stby, conv;
  int err_total = 0, checks = 0, cyc = 0, convs = 0;
  tmr_if tmr_if_i ();
  tmr_device tmr_device_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .bus(tmr_if_i.device),
    .i_local_temp(ltemp), .i_remote_temp(rtemp), .i_remote_quarter(rquart), .i_remote_short(rshort),
    .i_alarm_flag(alarm), .i_overtemp_flag(otemp), .i_high_flag(high), .o_irq_output_b(irq_b),
    .o_overtemp_output_b(ot_b), .o_conv_strobe(conv), .o_standby(stby));
  tmr_host tmr_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .link(tmr_if_i.host));
  tmr_checker tmr_checker_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .wr_stb(tmr_if_i.wr_stb),
    .rd_stb(tmr_if_i.rd_stb), .ptr_only(tmr_if_i.ptr_only), .wr_ptr(tmr_if_i.wr_ptr),
    .wr_data(tmr_if_i.wr_data), .rd_data(tmr_if_i.rd_data), .rd_valid(tmr_if_i.rd_valid));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pin 6 level: second overtemp ignores the mask, alert mode honours it
  function automatic logic irq_exp(input logic [7:0] c, input logic a, input logic h);
    return c[CFG_PIN6_BIT] ? !h : !(a && !c[CFG_IRQ_MASK_BIT]);
  endfunction
  // Expected result byte: binary clamped to 0..127, or offset binary clamped to the byte
  function automatic logic [7:0] fmt_exp(input int t, input logic ext);
    int o;
    o = ext ? t + int'(EXT_OFFSET) : t;
    if (o < 0) return BIN_MIN;
    if (o > (ext ? int'(EXT_MAX) : int'(BIN_MAX))) return ext ? EXT_MAX[7:0] : BIN_MAX;
    return o[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; address held until hready, data until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  // Issue a link command, then poll busy with a bounded count
  task automatic op(input logic [31:0] c);
    int n;
    n = 0;
    ahb(1'b1, HC_CMD, c | HC_CMD_GO_BIT);
    do begin
      ahb(1'b0, HC_STATUS, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 20);
    chk({7'h0, rv[0]}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, HC_WDATA, {24'h0, d});
    op(WR_CMD | {24'h0, a});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    op(PTR_CMD | {24'h0, a});
    op(32'h0);
    ahb(1'b0, HC_RDATA, 32'h0);
    q = rv[7:0];
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #50 i_clock = ~i_clock;
  // Hang guard, far above the under two thousand cycles the tests need; also counts conversions
  always @(posedge i_clock) begin
    cyc++;
    if (conv === 1'b1) convs++;
    if (cyc == 30000) begin
      err_total++;
      $display("BAD t=%0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    logic [7:0] q, v, r, e_loc, e_int, e_frac;
    logic signed [9:0] lt, rt;
    logic sh;
    logic [7:0] modes [3];
    modes = '{8'h40, 8'hc0, 8'he0};
    // Reset release converts once, so the local result holds the preset sample
    e_loc = fmt_exp(ltemp, 1'b0);
    e_int = RESULT_RESET;
    e_frac = RESULT_RESET;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    op(32'h0);
    ahb(1'b0, HC_RDATA, 32'h0);
    chk(rv[7:0], e_loc);
    rd(ADDR_CFG_RD, q); chk(q, CFG_RESET);
    rd(ADDR_RATE_RD, q); chk(q, RATE_RESET);
    rd(ADDR_REM_INT, q); chk(q, RESULT_RESET);
    rd(ADDR_REM_FRAC, q); chk(q, RESULT_RESET);
    $display("test reset values done");
    // Random config, rate and samples, end rate codes first; even passes enter standby,
    // odd passes leave it and so start exactly one conversion
    for (int i = 0; i < 12; i++) begin
      lfsr_reg = nxt(lfsr_reg);
      v = lfsr_reg[7:0] & CFG_WR_MASK;
      v[CFG_STANDBY_BIT] = (i % 2 == 0);
      r = (i == 0) ? 8'h00 : (i == 1) ? {4'h0, RATE_MAX_CODE} : {4'h0, lfsr_reg[11:8] % 4'hb};
      lt = 10'($signed(lfsr_reg[24:16]));
      rt = 10'($signed(lfsr_reg[30:22]));
      sh = lfsr_reg[14];
      // Corner: extended range at both ends of the representable span
      if (i == 1) begin
        v[CFG_RANGE_BIT] = 1'b1;
        lt = -10'sd64;
        rt = 10'sd191;
        sh = 1'b0;
      end
      ltemp <= lt;
      rtemp <= rt;
      rquart <= lfsr_reg[13:12];
      rshort <= sh;
      wr(ADDR_CFG_WR, v);
      if (!v[CFG_STANDBY_BIT]) begin
        e_loc = fmt_exp(lt, v[CFG_RANGE_BIT]);
        if (!sh) begin
          e_int = fmt_exp(rt, v[CFG_RANGE_BIT]);
          e_frac = {lfsr_reg[13:12], 6'h00};
        end
      end
      wr(ADDR_RATE_WR, r);
      rd(ADDR_LOCAL, q);
      chk(q, e_loc);
      rd(ADDR_REM_INT, q);
      chk(q, e_int);
      rd(ADDR_REM_FRAC, q);
      chk(q, e_frac);
      rd(ADDR_CFG_RD, q); chk(q, v);
      chk({7'h0, stby}, {7'h0, v[CFG_STANDBY_BIT]});
      rd(ADDR_RATE_RD, q); chk(q, r);
    end
    $display("test config and rate done");
    wr(ADDR_LOCAL, 8'h5a);
    rd(ADDR_LOCAL, q); chk(q, e_loc);
    wr(8'h20, 8'h77);
    rd(8'h20, q); chk(q, UNMAPPED_READ);
    rd(ADDR_CFG_RD, q); chk(q, v);
    $display("test read-only and unmapped done");
    // Pin 6 modes, all in standby so the outputs must stay live
    alarm <= 1'b1;
    otemp <= 1'b1;
    high <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG_WR, modes[i]);
      chk({7'h0, irq_b}, {7'h0, irq_exp(modes[i], 1'b1, 1'b1)});
      chk({7'h0, ot_b}, 8'h00);
    end
    $display("test pin six modes done");
    chk(8'(convs), 8'h07);
    end_sim();
  end
endmodule
